// File: logic/pcr_regs.sv
// What this block does
// RULE1: The accel enable turns on accelerated arbitration, resets to 0, survives bus reset, is off in beta mode.
// RULE2: Software sets the accel enable only with an enhanced-revision link controller attached.
// RULE3: The multispeed enable allows mixed-speed concatenation, resets to 0, survives bus reset, is off in beta mode.
// RULE4: Software sets the multispeed enable only with an enhanced-revision link controller attached.
// RULE5: A read-only 3-bit field keeps the top legacy speed seen in self-ID packets, capped at S400.
// RULE6: A read-only flag shows the synchronised beta-mode pin.
// RULE7: A writable 2-bit bridge field, reset 0, feeds the self-ID bridge bits.
// RULE8: A writable 3-bit page selector picks the page at 8 to 15, resets to 0, survives bus reset.
// RULE9: A writable 4-bit port selector, ports from zero, resets to 0, survives bus reset.
// RULE10: Software reaches a port page by writing page 0 and the port number into register 7.
// RULE11: A selected port that does not exist reads as zero in every port page register.
// RULE12: Register 13 of the port page holds loop disable, in standby and hard disable; upper bits reserved.
// RULE13: Each pair's line state reads as a 2-bit code: 11 Z, 01 one, 10 zero, 00 invalid.
// RULE14: The connected flag sets after about 341 ms of stable connection and clears on hard reset only; the code clears it when the connect pin drops.
// RULE15: The port disable bit keeps the port inactive, resets to 0, survives bus reset.
// RULE16: Reserved addresses and bits ignore writes and read as zero.
`timescale 1ns/100ps
`include "pcr_defines.svh"
module pcr_regs import pcr_pkg::*; #(
  parameter int unsigned DEBOUNCE_CYCLES = `PCR_DEBOUNCE_CYC
) (
  // Clock and reset.
  input  wire logic                                aclk,
  input  wire logic                                aresetn,
  // AXI4-Lite slave.
  input  wire logic [7:0]                          awaddr,
  input  wire logic [2:0]                          awprot,
  input  wire logic                                awvalid,
  output logic                                     awready_ff,
  input  wire logic [31:0]                         wdata,
  input  wire logic [3:0]                          wstrb,
  input  wire logic                                wvalid,
  output logic                                     wready_ff,
  output logic [1:0]                               bresp_ff,
  output logic                                     bvalid_ff,
  input  wire logic                                bready,
  input  wire logic [7:0]                          araddr,
  input  wire logic [2:0]                          arprot,
  input  wire logic                                arvalid,
  output logic                                     arready_ff,
  output logic [31:0]                              rdata_ff,
  output logic [1:0]                               rresp_ff,
  output logic                                     rvalid_ff,
  input  wire logic                                rready,
  // Physical-layer state.
  input  wire logic                                bus_reset,
  input  wire logic                                beta_mode_active,
  input  wire logic                                beta_mode_pin,
  input  wire logic                                selfid_valid,
  input  wire logic                                selfid_legacy,
  input  wire logic [2:0]                          selfid_speed,
  input  wire logic [`PCR_NUM_PORTS*4-1:0]         port_line_pins,
  input  wire logic [`PCR_NUM_PORTS-1:0]           port_connect_pins,
  input  wire pcr_port_stat_t [`PCR_NUM_PORTS-1:0] port_stat,
  // Controls to the physical layer.
  output logic                                     accel_arb_active_ff,
  output logic                                     multispeed_concat_active_ff,
  output logic [1:0]                               bridge_bits_ff,
  output pcr_port_ctl_t [`PCR_NUM_PORTS-1:0]       port_ctl_ff
);

  localparam int NP = `PCR_NUM_PORTS;
  localparam int SW = NP * 5 + 1;

  // ==========================================================================
  // Address decode
  function automatic logic [3:0] reg_index(input logic [7:0] a);
    reg_index = a[5:2];
  endfunction : reg_index

  function automatic logic is_mapped(input logic [7:0] a);
    logic [3:0] i;
    i = a[5:2];
    is_mapped = (a[7:6] == 2'h0) && (a[1:0] == 2'h0) &&
                ((i == `PCR_IDX_BASE_CTL) || (i >= `PCR_IDX_SELECT));
  endfunction : is_mapped

  // ==========================================================================
  // Pin synchronisers and connection debounce
  logic [SW-1:0] sync_q;
  logic [NP-1:0] con;

  pcr_sync #(.W(SW)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d_in    ({beta_mode_pin, port_connect_pins, port_line_pins}),
    .q_ff    (sync_q)
  );

  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++)
    begin : g_deb
      pcr_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_deb ( // RULE14
        .aclk    (aclk),
        .aresetn (aresetn),
        .raw     (sync_q[NP*4 + gp]),
        .con_ff  (con[gp])
      );
    end
  endgenerate

  // ==========================================================================
  // Register state
  logic                 accel_en_ff, nxt_accel_en;
  logic                 multi_en_ff, nxt_multi_en;
  logic [1:0]           bridge_ff, nxt_bridge;
  logic [2:0]           page_ff, nxt_page;
  logic [3:0]           port_sel_ff, nxt_port_sel;
  logic [2:0]           legacy_ff, nxt_legacy;
  logic [NP-1:0]        fault_ff, nxt_fault;
  logic [NP-1:0]        sbfault_ff, nxt_sbfault;
  pcr_port_ctl_t [NP-1:0] nxt_port_ctl;
  logic                 aw_got_ff, nxt_aw_got;
  logic                 w_got_ff, nxt_w_got;
  logic [7:0]           awaddr_ff, nxt_awaddr;
  logic [31:0]          wdata_ff, nxt_wdata;
  logic [3:0]           wstrb_ff, nxt_wstrb;
  logic                 nxt_bvalid, nxt_rvalid;
  logic [1:0]           nxt_bresp, nxt_rresp;
  logic [31:0]          nxt_rdata;
  logic                 wr_do;
  logic                 sel_valid;
  logic [1:0]           ps;
  logic [2:0]           cand;
  logic                 beta_link_present;

  assign beta_link_present     = sync_q[SW-1]; // RULE6
  assign ps        = port_sel_ff[1:0];
  assign sel_valid = (page_ff == `PCR_PAGE_PORT) && (port_sel_ff < 4'(NP)); // RULE10 RULE11
  assign wr_do     = aw_got_ff && w_got_ff && !bvalid_ff;
  assign cand      = (selfid_speed > `PCR_SPEED_CAP) ? `PCR_SPEED_CAP : selfid_speed; // RULE5

  // ==========================================================================
  // Next-state logic
  always_comb
  begin
    nxt_accel_en = accel_en_ff;
    nxt_multi_en = multi_en_ff;
    nxt_bridge   = bridge_ff;
    nxt_page     = page_ff;
    nxt_port_sel = port_sel_ff;
    nxt_legacy   = legacy_ff;
    nxt_port_ctl = port_ctl_ff;
    nxt_aw_got   = aw_got_ff;
    nxt_w_got    = w_got_ff;
    nxt_awaddr   = awaddr_ff;
    nxt_wdata    = wdata_ff;
    nxt_wstrb    = wstrb_ff;
    nxt_bvalid   = bvalid_ff;
    nxt_bresp    = bresp_ff;
    nxt_rvalid   = rvalid_ff;
    nxt_rresp    = rresp_ff;
    nxt_rdata    = rdata_ff;
    // Sticky faults: the event wins over a same-cycle clear.
    for (int p = 0; p < NP; p++)
    begin
      nxt_fault[p]   = port_stat[p].fault_evt | fault_ff[p];
      nxt_sbfault[p] = port_stat[p].sb_fault_evt | (sbfault_ff[p] & ~port_stat[p].sb_exit);
    end
    if (bus_reset)
      nxt_legacy = 3'h0;
    else if (selfid_valid && selfid_legacy && (cand > legacy_ff))
      nxt_legacy = cand; // RULE5
    // Write channel.
    if (awvalid && awready_ff)
    begin
      nxt_aw_got = 1'b1;
      nxt_awaddr = awaddr;
    end
    if (wvalid && wready_ff)
    begin
      nxt_w_got = 1'b1;
      nxt_wdata = wdata;
      nxt_wstrb = wstrb;
    end
    if (bvalid_ff && bready)
      nxt_bvalid = 1'b0;
    if (wr_do)
    begin
      nxt_aw_got = 1'b0;
      nxt_w_got  = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = is_mapped(awaddr_ff) ? `PCR_RESP_OKAY : `PCR_RESP_SLVERR;
      if (is_mapped(awaddr_ff) && wstrb_ff[0])
      begin
        case (reg_index(awaddr_ff))
          `PCR_IDX_BASE_CTL:
          begin
            nxt_accel_en = wdata_ff[`PCR_F_ACCEL]; // RULE1
            nxt_multi_en = wdata_ff[`PCR_F_MULTI]; // RULE3
            nxt_bridge   = wdata_ff[`PCR_F_BRIDGE_LSB +: 2]; // RULE7
          end
          `PCR_IDX_SELECT:
          begin
            nxt_page     = wdata_ff[`PCR_F_PAGE_LSB +: 3]; // RULE8
            nxt_port_sel = wdata_ff[`PCR_F_PORT_LSB +: 4]; // RULE9
          end
          `PCR_IDX_LINE:
            if (sel_valid)
              nxt_port_ctl[ps].port_off = wdata_ff[`PCR_F_DIS]; // RULE15
          `PCR_IDX_SPEED:
            if (sel_valid)
            begin
              nxt_port_ctl[ps].event_enable = wdata_ff[`PCR_F_PIE];
              nxt_port_ctl[ps].scram_off    = wdata_ff[`PCR_F_SCRAMOFF];
              if (wdata_ff[`PCR_F_FAULT])
                nxt_fault[ps] = port_stat[ps].fault_evt;
              if (wdata_ff[`PCR_F_SBFAULT])
                nxt_sbfault[ps] = port_stat[ps].sb_fault_evt;
            end
          `PCR_IDX_LOOP:
            if (sel_valid)
            begin
              nxt_port_ctl[ps].loop_off = wdata_ff[`PCR_F_LOOPDIS]; // RULE12
              nxt_port_ctl[ps].hard_off = wdata_ff[`PCR_F_HARDDIS];
            end
          default:
            nxt_page = page_ff; // RULE16
        endcase
      end
    end
    // Read channel.
    if (rvalid_ff && rready)
      nxt_rvalid = 1'b0;
    if (arvalid && arready_ff)
    begin
      nxt_rvalid = 1'b1;
      nxt_rdata  = 32'h0;
      nxt_rresp  = is_mapped(araddr) ? `PCR_RESP_OKAY : `PCR_RESP_SLVERR;
      if (is_mapped(araddr))
      begin
        case (reg_index(araddr))
          `PCR_IDX_BASE_CTL:
            nxt_rdata[7:0] = {bridge_ff, beta_link_present, legacy_ff, multi_en_ff, accel_en_ff};
          `PCR_IDX_SELECT:
            nxt_rdata[7:0] = {page_ff, 1'b0, port_sel_ff};
          `PCR_IDX_LINE:
            if (sel_valid)
              nxt_rdata[7:0] = {sync_q[ps*4 +: 4], port_stat[ps].is_downstream_port,
                                con[ps], port_stat[ps].receive_good,
                                port_ctl_ff[ps].port_off}; // RULE13 RULE14
          `PCR_IDX_SPEED:
            if (sel_valid)
              nxt_rdata[7:0] = {port_stat[ps].neg_speed, port_ctl_ff[ps].event_enable,
                                fault_ff[ps], sbfault_ff[ps],
                                port_ctl_ff[ps].scram_off, 1'b0};
          `PCR_IDX_CAPAB:
            if (sel_valid)
              nxt_rdata[7:0] = {port_stat[ps].dc_connected, `PCR_PORT_SPEED,
                                port_stat[ps].lpp, port_stat[ps].cable_speed};
          `PCR_IDX_RELIAB:
            if (sel_valid)
              nxt_rdata[7:0] = {port_stat[ps].conn_unreliable, 2'h0,
                                port_stat[ps].beta_mode, 4'h0};
          `PCR_IDX_ERRCNT:
            if (sel_valid)
              nxt_rdata[7:0] = port_stat[ps].err_count;
          `PCR_IDX_LOOP:
            if (sel_valid)
              nxt_rdata[7:0] = {5'h0, port_ctl_ff[ps].loop_off,
                                port_stat[ps].in_standby, port_ctl_ff[ps].hard_off}; // RULE12
          default:
            nxt_rdata = 32'h0; // RULE16
        endcase
      end
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      accel_en_ff                 <= 1'b0;
      multi_en_ff                 <= 1'b0;
      bridge_ff                   <= `PCR_RST_BRIDGE;
      page_ff                     <= `PCR_RST_PAGE;
      port_sel_ff                 <= `PCR_RST_PORT;
      legacy_ff                   <= 3'h0;
      fault_ff                    <= '0;
      sbfault_ff                  <= '0;
      port_ctl_ff                 <= '0;
      aw_got_ff                   <= 1'b0;
      w_got_ff                    <= 1'b0;
      awaddr_ff                   <= 8'h0;
      wdata_ff                    <= 32'h0;
      wstrb_ff                    <= 4'h0;
      awready_ff                  <= 1'b0;
      wready_ff                   <= 1'b0;
      bvalid_ff                   <= 1'b0;
      bresp_ff                    <= `PCR_RESP_OKAY;
      arready_ff                  <= 1'b0;
      rvalid_ff                   <= 1'b0;
      rresp_ff                    <= `PCR_RESP_OKAY;
      rdata_ff                    <= 32'h0;
      accel_arb_active_ff         <= 1'b0;
      multispeed_concat_active_ff <= 1'b0;
      bridge_bits_ff              <= `PCR_RST_BRIDGE;
    end
    else
    begin
      accel_en_ff                 <= nxt_accel_en;
      multi_en_ff                 <= nxt_multi_en;
      bridge_ff                   <= nxt_bridge;
      page_ff                     <= nxt_page;
      port_sel_ff                 <= nxt_port_sel;
      legacy_ff                   <= nxt_legacy;
      fault_ff                    <= nxt_fault;
      sbfault_ff                  <= nxt_sbfault;
      port_ctl_ff                 <= nxt_port_ctl;
      aw_got_ff                   <= nxt_aw_got;
      w_got_ff                    <= nxt_w_got;
      awaddr_ff                   <= nxt_awaddr;
      wdata_ff                    <= nxt_wdata;
      wstrb_ff                    <= nxt_wstrb;
      awready_ff                  <= !nxt_aw_got && !nxt_bvalid;
      wready_ff                   <= !nxt_w_got && !nxt_bvalid;
      bvalid_ff                   <= nxt_bvalid;
      bresp_ff                    <= nxt_bresp;
      arready_ff                  <= !nxt_rvalid;
      rvalid_ff                   <= nxt_rvalid;
      rresp_ff                    <= nxt_rresp;
      rdata_ff                    <= nxt_rdata;
      accel_arb_active_ff         <= accel_en_ff & ~beta_mode_active; // RULE1
      multispeed_concat_active_ff <= multi_en_ff & ~beta_mode_active; // RULE3
      bridge_bits_ff              <= bridge_ff; // RULE7
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  accel_beta_off_a: assert property (beta_mode_active |=> !accel_arb_active_ff) // RULE1
    else $error("accel arbitration active in beta mode");
  concat_beta_off_a: assert property (beta_mode_active |=> !multispeed_concat_active_ff) // RULE3
    else $error("multispeed concat active in beta mode");
  legacy_cap_a: assert property (legacy_ff <= `PCR_SPEED_CAP) // RULE5
    else $error("legacy speed above cap");
  bridge_write_a: assert property (wr_do && wstrb_ff[0] && awaddr_ff == {2'h0, `PCR_IDX_BASE_CTL, 2'h0}
    |=> ##1 bridge_bits_ff == $past(wdata_ff[7:6], 2)) // RULE7
    else $error("bridge bits not updated");
  select_busreset_a: assert property (bus_reset && !wr_do |=> $stable(page_ff) && $stable(port_sel_ff)) // RULE8
    else $error("selectors changed on bus reset");
  absent_port_zero_a: assert property (arvalid && arready_ff && !sel_valid && reg_index(araddr) >= `PCR_IDX_LINE
    |=> rdata_ff == 32'h0) // RULE11
    else $error("port page not zero");
  loop_reserved_a: assert property (arvalid && arready_ff && reg_index(araddr) == `PCR_IDX_LOOP
    |=> rdata_ff[31:3] == 29'h0) // RULE12
    else $error("loop register reserved bits set");
  con_drop_a: assert property (!sync_q[NP*4] |=> !con[0]) // RULE14
    else $error("connected while disconnected");
  disable_write_a: assert property (wr_do && wstrb_ff[0] && sel_valid && port_sel_ff == 4'h0
    && awaddr_ff == {2'h0, `PCR_IDX_LINE, 2'h0} |=> port_ctl_ff[0].port_off == $past(wdata_ff[0])) // RULE15
    else $error("port disable not written");
  spare_zero_a: assert property (arvalid && arready_ff && reg_index(araddr) == `PCR_IDX_SPARE_E
    |=> rdata_ff == 32'h0) // RULE16
    else $error("spare register not zero");

  write_done_c: cover property (wr_do ##1 bvalid_ff && bready);
  port_read_c: cover property (arvalid && arready_ff && sel_valid && reg_index(araddr) == `PCR_IDX_LINE);
  con_rise_c: cover property ($rose(con[0]));
  legacy_seen_c: cover property ($rose(legacy_ff == `PCR_SPEED_CAP));

endmodule : pcr_regs

// File: logic/pcr_defines.svh
`ifndef PCR_DEFINES_SVH
`define PCR_DEFINES_SVH

// Register indices; the byte address is four times the index.
`define PCR_IDX_BASE_CTL   4'h5
`define PCR_IDX_SELECT     4'h7
`define PCR_IDX_LINE       4'h8
`define PCR_IDX_SPEED      4'h9
`define PCR_IDX_CAPAB      4'ha
`define PCR_IDX_RELIAB     4'hb
`define PCR_IDX_ERRCNT     4'hc
`define PCR_IDX_LOOP       4'hd
`define PCR_IDX_SPARE_E    4'he
`define PCR_IDX_SPARE_F    4'hf

// Field positions.
`define PCR_F_ACCEL        0
`define PCR_F_MULTI        1
`define PCR_F_BRIDGE_LSB   6
`define PCR_F_PAGE_LSB     5
`define PCR_F_PORT_LSB     0
`define PCR_F_DIS          0
`define PCR_F_PIE          4
`define PCR_F_FAULT        3
`define PCR_F_SBFAULT      2
`define PCR_F_SCRAMOFF     1
`define PCR_F_LOOPDIS      2
`define PCR_F_HARDDIS      0

// Reset values and fixed codes.
`define PCR_NUM_PORTS      3
`define PCR_PAGE_PORT      3'h0
`define PCR_SPEED_CAP      3'h2
`define PCR_PORT_SPEED     3'h3
`define PCR_RST_BRIDGE     2'h0
`define PCR_RST_PAGE       3'h0
`define PCR_RST_PORT       4'h0
`define PCR_RESP_OKAY      2'h0
`define PCR_RESP_SLVERR    2'h2

// Timing.
`define PCR_CLK_HZ         20000000
`define PCR_DEBOUNCE_MS    341
`define PCR_DEBOUNCE_CYC   (`PCR_DEBOUNCE_MS * (`PCR_CLK_HZ / 1000))

`endif

// File: logic/pcr_pkg.sv
package pcr_pkg;

  // Same-clock status from the port logic.
  typedef struct packed {
    logic       is_downstream_port;
    logic       receive_good;
    logic [2:0] neg_speed;
    logic       fault_evt;
    logic       sb_fault_evt;
    logic       sb_exit;
    logic       dc_connected;
    logic       lpp;
    logic [2:0] cable_speed;
    logic       conn_unreliable;
    logic       beta_mode;
    logic [7:0] err_count;
    logic       in_standby;
  } pcr_port_stat_t;

  // Per-port controls driven to the port logic.
  typedef struct packed {
    logic port_off;
    logic event_enable;
    logic scram_off;
    logic loop_off;
    logic hard_off;
  } pcr_port_ctl_t;

endpackage : pcr_pkg

// File: logic/pcr_sync.sv
`timescale 1ns/100ps
module pcr_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Asynchronous levels in, filtered levels out.
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_ff
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] nxt_q;

  // A bit changes once the second and third stages agree.
  always_comb
  begin
    nxt_q = (s2_ff & s3_ff) | (q_ff & (s2_ff ^ s3_ff));
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      q_ff  <= '0;
    end
    else
    begin
      s1_ff <= d_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff  <= nxt_q;
    end
  end

endmodule : pcr_sync

// File: logic/pcr_debounce.sv
`timescale 1ns/100ps
module pcr_debounce #(
  parameter int unsigned CYCLES = 1
) (
  // Clock and reset.
  input  wire logic aclk,
  input  wire logic aresetn,
  // Synchronised raw connection, debounced flag.
  input  wire logic raw,
  output logic      con_ff
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          nxt_con;

  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_con = con_ff;
    if (!raw)
    begin
      nxt_cnt = '0;
      nxt_con = 1'b0;
    end
    else if (!con_ff)
    begin
      if (cnt_ff == CW'(CYCLES - 1))
        nxt_con = 1'b1;
      else
        nxt_cnt = cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_ff <= '0;
      con_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      con_ff <= nxt_con;
    end
  end

endmodule : pcr_debounce

// File: sim/pcr_phy_model.sv
`timescale 1ns/100ps
module pcr_phy_model import pcr_pkg::*; #(
  parameter int N = 3
) (
  // Status toward the register block.
  output pcr_port_stat_t [N-1:0] port_stat
);
  // Each port shows its own pattern so that reads can tell the ports apart.
  always_comb
  begin
    for (int p = 0; p < N; p++)
    begin
      port_stat[p]                    = '0;
      port_stat[p].is_downstream_port = p[0];
      port_stat[p].receive_good       = 1'b1;
      port_stat[p].err_count          = 8'h10 + 8'(p);
    end
  end
endmodule : pcr_phy_model

// File: sim/tb_phy_config_and_port_page_regs.sv
`timescale 1ns/100ps
`include "pcr_defines.svh"
module tb_phy_config_and_port_page_regs import pcr_pkg::*;;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, bus_reset = 1'b0, beta_mode_active = 1'b0;
  logic beta_mode_pin = 1'b0, selfid_valid = 1'b0, selfid_legacy = 1'b1;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata_ff, rd, s = 32'ha7e743b0;
  logic [2:0]  selfid_speed = 3'h0, port_connect_pins = 3'h0;
  logic [11:0] port_line_pins = 12'h0;
  logic        awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic        accel_arb_active_ff, multispeed_concat_active_ff;
  logic [1:0]  bresp_ff, rresp_ff, bridge_bits_ff, rsp;
  pcr_port_stat_t [2:0] port_stat;
  pcr_port_ctl_t [2:0]  port_ctl_ff;
  int          n_errors = 0, n_checks = 0, mx = 0;

  always #25 aclk = ~aclk;

  pcr_phy_model #(.N(3)) phy (.port_stat);
  pcr_regs #(.DEBOUNCE_CYCLES(16)) uut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid,
    .awready_ff, .wdata, .wstrb(4'hf), .wvalid, .wready_ff, .bresp_ff, .bvalid_ff, .bready,
    .araddr, .arprot(3'h0), .arvalid, .arready_ff, .rdata_ff, .rresp_ff, .rvalid_ff, .rready,
    .bus_reset, .beta_mode_active, .beta_mode_pin, .selfid_valid, .selfid_legacy,
    .selfid_speed, .port_line_pins, .port_connect_pins, .port_stat, .accel_arb_active_ff,
    .multispeed_concat_active_ff, .bridge_bits_ff, .port_ctl_ff);

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  function automatic logic [31:0] exp_base(input logic [7:0] d, input logic [2:0] sp,
                                           input logic b);
    return {24'h0, d[7:6], b, sp, d[1:0]};
  endfunction : exp_base

  function automatic logic [31:0] exp_line(input logic [11:0] pins, input int p);
    return {24'h0, pins[p*4 +: 4], p[0], 1'b0, 1'b1, 1'b0};
  endfunction : exp_line

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int   n;
    logic aw, w;
    n = 0;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while ((aw || w) && n < 100)
    begin
      @(posedge aclk);
      n++;
      if (aw && awready_ff) awvalid <= 1'b0;
      if (w && wready_ff) wvalid <= 1'b0;
      aw = aw && !awready_ff;
      w = w && !wready_ff;
    end
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid_ff && ++n < 200);
    r = bresp_ff;
    bready <= 1'b0;
    if (n >= 200) n_errors++;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready_ff && ++n < 100);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid_ff && ++n < 200);
    d = rdata_ff;
    r = rresp_ff;
    rready <= 1'b0;
    if (n >= 200) n_errors++;
  endtask : axi_rd

  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (5000) @(posedge aclk);
    n_errors++;
    summarize();
  end

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(8'h14, rd, rsp);
    chk("base reset", rd, 32'h0);
    axi_rd(8'h1c, rd, rsp);
    chk("select reset", rd, 32'h0);
    for (int i = 0; i < 7; i++)
    begin
      s = lfsr(s);
      if (i == 0) s[7:0] = 8'hff;
      if (i == 6) s[7:0] = 8'h03;
      axi_wr(8'h14, {24'h0, s[7:0]}, rsp);
      axi_rd(8'h14, rd, rsp);
      chk("base", rd, exp_base(s[7:0], 3'h0, 1'b0));
      chk("accel out", accel_arb_active_ff, s[0]);
      chk("multi out", multispeed_concat_active_ff, s[1]);
      chk("bridge out", bridge_bits_ff, s[7:6]);
    end
    beta_mode_active <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("accel beta", accel_arb_active_ff, 1'b0);
    chk("multi beta", multispeed_concat_active_ff, 1'b0);
    beta_mode_active <= 1'b0;
    $display("base field test done");
    for (int sp = 0; sp < 5; sp++)
    begin
      selfid_speed <= sp[2:0];
      selfid_legacy <= sp != 1;
      selfid_valid <= 1'b1;
      @(posedge aclk);
      selfid_valid <= 1'b0;
      if (sp != 1 && sp > mx) mx = sp > 2 ? 2 : sp;
      axi_rd(8'h14, rd, rsp);
      chk("legacy speed", rd, exp_base(8'h03, mx[2:0], 1'b0));
    end
    beta_mode_pin <= 1'b1;
    bus_reset <= 1'b1;
    @(posedge aclk);
    bus_reset <= 1'b0;
    repeat (8) @(posedge aclk);
    axi_rd(8'h14, rd, rsp);
    chk("bus reset", rd, exp_base(8'h03, 3'h0, 1'b1));
    $display("self-id test done");
    for (int p = 0; p < 4; p++)
    begin
      s = lfsr(s);
      port_line_pins <= s[11:0];
      axi_wr(8'h1c, p, rsp);
      repeat (6) @(posedge aclk);
      axi_rd(8'h1c, rd, rsp);
      chk("select", rd, p);
      axi_rd(8'h20, rd, rsp);
      chk("line", rd, p < 3 ? exp_line(s[11:0], p) : 32'h0);
      axi_rd(8'h30, rd, rsp);
      chk("errcnt", rd, p < 3 ? 32'h10 + p : 32'h0);
    end
    axi_wr(8'h1c, 32'h20, rsp);
    axi_rd(8'h20, rd, rsp);
    chk("page one", rd, 32'h0);
    axi_wr(8'h1c, 32'h0, rsp);
    port_connect_pins <= 3'b001;
    axi_wr(8'h20, 32'hff, rsp);
    axi_wr(8'h34, 32'hff, rsp);
    axi_rd(8'h20, rd, rsp);
    chk("con early", rd, exp_line(port_line_pins, 0) | 32'h1);
    repeat (40) @(posedge aclk);
    axi_rd(8'h20, rd, rsp);
    chk("con late", rd, exp_line(port_line_pins, 0) | 32'h5);
    chk("port off", port_ctl_ff[0].port_off, 1'b1);
    axi_rd(8'h34, rd, rsp);
    chk("loop reg", rd, 32'h5);
    chk("hard off", {port_ctl_ff[0].loop_off, port_ctl_ff[0].hard_off}, 2'h3);
    axi_wr(8'h24, 32'h1f, rsp);
    axi_rd(8'h24, rd, rsp);
    chk("speed reg", rd, 32'h12);
    chk("speed ctl", {port_ctl_ff[0].event_enable, port_ctl_ff[0].scram_off}, 2'h3);
    axi_rd(8'h28, rd, rsp);
    chk("capab", rd, {24'h0, 1'b0, `PCR_PORT_SPEED, 4'h0});
    axi_rd(8'h38, rd, rsp);
    chk("spare", rd, 32'h0);
    axi_wr(8'h18, 32'hff, rsp);
    chk("unmapped wr", rsp, `PCR_RESP_SLVERR);
    axi_rd(8'h54, rd, rsp);
    chk("unmapped rd", {rd[29:0], rsp}, {30'h0, `PCR_RESP_SLVERR});
    $display("port page test done");
    axi_wr(8'h1c, 32'hff, rsp);
    axi_rd(8'h1c, rd, rsp);
    chk("select rsvd", rd, 32'hef);
    axi_wr(8'h14, 32'hc3, rsp);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    chk("out reset", {accel_arb_active_ff, multispeed_concat_active_ff}, 2'h0);
    chk("ctl reset", {bridge_bits_ff, port_ctl_ff}, 17'h0);
    axi_rd(8'h14, rd, rsp);
    chk("base hard reset", rd, exp_base(8'h00, 3'h0, 1'b1));
    axi_rd(8'h1c, rd, rsp);
    chk("select hard reset", rd, 32'h0);
    $display("hard reset test done");
    summarize();
  end
endmodule : tb_phy_config_and_port_page_regs
